/* hw/dpllc_pkg.sv */
// Purpose: Shared constants and types for the dual PLL divider and lock block.
// Assumes: Byte-wide register port from the serial interface engine.
// Notes:   All offsets, reset values and counts used by the logic live here.
package dpllc_pkg;
  localparam logic [7:0]  ADDR_PV_LO   = 8'h10;
  localparam logic [7:0]  ADDR_PV_HI   = 8'h11;
  localparam logic [7:0]  ADDR_MV_LO   = 8'h12;
  localparam logic [7:0]  ADDR_MV_HI   = 8'h13;
  localparam logic [7:0]  ADDR_LW_LO   = 8'h15;
  localparam logic [7:0]  ADDR_LW_HI   = 8'h16;
  localparam logic [7:0]  ADDR_PF_FDF  = 8'h19;
  localparam logic [7:0]  ADDR_MF_LO   = 8'h1A;
  localparam logic [7:0]  ADDR_MF_MSB  = 8'h1B;
  localparam logic [14:0] PV_RST       = 15'h0400;
  localparam logic [14:0] MV_RST       = 15'h0400;
  localparam logic [14:0] LW_RST       = 15'h0080;
  localparam logic [5:0]  PF_RST       = 6'h01;
  localparam logic [8:0]  MF_RST       = 9'h018;
  localparam int          FDF_BIT      = 7;
  localparam logic [9:0]  LOCK_CYCLES  = 10'h3E8;
  localparam logic [15:0] PH_MAX       = 16'hFFFF;

  typedef struct packed {
    logic [7:0]  pvLo;
    logic [6:0]  pvHi;
    logic [14:0] refPreDivider;
    logic [7:0]  mvLo;
    logic [6:0]  mvHi;
    logic [14:0] vcxoFeedbackDivider;
    logic [7:0]  lwLo;
    logic [6:0]  lwHi;
    logic [14:0] lockPhaseWindow;
    logic [5:0]  synthPreDivider;
    logic        synthDoublerSelect;
    logic [7:0]  mfLo;
    logic        mfMsb;
    logic [8:0]  synthFeedbackDivider;
    logic [14:0] refCnt;
    logic [14:0] vcxoCnt;
    logic [5:0]  preCnt;
    logic [8:0]  fbCnt;
    logic        refPrev;
    logic        vcxoPrev;
    logic        muxPrev;
    logic        vcoPrev;
    logic        refTick;
    logic        vcxoTick;
    logic        synthTick;
    logic        fbTick;
    logic        phRun;
    logic        phRefFirst;
    logic [15:0] phCnt;
    logic [9:0]  lockCnt;
    logic        locked;
    logic [7:0]  rdData;
  } dpllc_state_t;
endpackage

/* hw/dpllc_core.sv */
// Purpose: Divider ratio registers, divided clock events and first stage lock detect.
// Assumes: All clock inputs are sampled synchronously; each divided clock is a one-cycle tick.
// Notes:   Phase difference is measured in system clock cycles between divided edges.
`timescale 1ns/10ps
module dpllc_core
  import dpllc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic       refClkIn,
  input  wire logic       vcxoClkIn,
  input  wire logic       vcoClkIn,
  input  wire logic       firstStageBypassSelect,
  output logic            refDivTick,
  output logic            dividedVcxoClock,
  output logic            synthRefTick,
  output logic            synthFbTick,
  output logic            lockDetect
);

  dpllc_state_t s_ff;
  dpllc_state_t nxt_s;
  logic         muxIn;
  logic         muxRise;
  logic         muxFall;
  logic         pairDone;
  logic         pairOk;

  // Counting up and comparing with >= means a smaller ratio applied mid-count
  // ends the current period early instead of wrapping through the full range.
  function automatic logic [15:0] divStep(input logic [14:0] cnt, input logic [14:0] ratio);
    logic [15:0] res;
    res = {1'b0, cnt + 15'h0001};
    if ((cnt + 15'h0001) >= ratio)
    begin
      res = {1'b1, 15'h0000};
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  assign muxIn   = firstStageBypassSelect ? refClkIn : vcxoClkIn;
  assign muxRise = muxIn & ~s_ff.muxPrev;
  assign muxFall = ~muxIn & s_ff.muxPrev;

  always_comb
  begin
    logic [15:0] st;
    logic        refRise;
    logic        vcxoRise;
    logic        vcoRise;
    st       = 16'h0000;
    nxt_s    = s_ff;
    pairDone = 1'b0;
    pairOk   = 1'b0;
    refRise  = refClkIn & ~s_ff.refPrev;
    vcxoRise = vcxoClkIn & ~s_ff.vcxoPrev;
    vcoRise  = vcoClkIn & ~s_ff.vcoPrev;
    if (ce)
    begin
      nxt_s.refPrev  = refClkIn;
      nxt_s.vcxoPrev = vcxoClkIn;
      nxt_s.muxPrev  = muxIn;
      nxt_s.vcoPrev  = vcoClkIn;

      // Register writes; high bytes commit the staged low byte.
      if (regWrEn)
      begin
        case (regAddr)
          ADDR_PV_LO:  nxt_s.pvLo = regWrData;
          ADDR_PV_HI:
          begin
            nxt_s.pvHi          = regWrData[6:0];
            nxt_s.refPreDivider = {regWrData[6:0], s_ff.pvLo};
          end
          ADDR_MV_LO:  nxt_s.mvLo = regWrData;
          ADDR_MV_HI:
          begin
            nxt_s.mvHi                = regWrData[6:0];
            nxt_s.vcxoFeedbackDivider = {regWrData[6:0], s_ff.mvLo};
          end
          ADDR_LW_LO:  nxt_s.lwLo = regWrData;
          ADDR_LW_HI:
          begin
            nxt_s.lwHi            = regWrData[6:0];
            nxt_s.lockPhaseWindow = {regWrData[6:0], s_ff.lwLo};
          end
          ADDR_PF_FDF:
          begin
            nxt_s.synthDoublerSelect = regWrData[FDF_BIT];
            nxt_s.synthPreDivider    = regWrData[5:0];
          end
          ADDR_MF_LO:  nxt_s.mfLo = regWrData;
          ADDR_MF_MSB:
          begin
            nxt_s.mfMsb                = regWrData[0];
            nxt_s.synthFeedbackDivider = {regWrData[0], s_ff.mfLo};
          end
          default: ;
        endcase
      end

      if (regRdEn)
      begin
        case (regAddr)
          ADDR_PV_LO:  nxt_s.rdData = s_ff.pvLo;
          ADDR_PV_HI:  nxt_s.rdData = {1'b0, s_ff.pvHi};
          ADDR_MV_LO:  nxt_s.rdData = s_ff.mvLo;
          ADDR_MV_HI:  nxt_s.rdData = {1'b0, s_ff.mvHi};
          ADDR_LW_LO:  nxt_s.rdData = s_ff.lwLo;
          ADDR_LW_HI:  nxt_s.rdData = {1'b0, s_ff.lwHi};
          ADDR_PF_FDF: nxt_s.rdData = {s_ff.synthDoublerSelect, 1'b0, s_ff.synthPreDivider};
          ADDR_MF_LO:  nxt_s.rdData = s_ff.mfLo;
          ADDR_MF_MSB: nxt_s.rdData = {7'h00, s_ff.mfMsb};
          default:     nxt_s.rdData = 8'h00;
        endcase
      end

      // First stage dividers.
      nxt_s.refTick = 1'b0;
      if (refRise)
      begin
        st            = divStep(s_ff.refCnt, s_ff.refPreDivider);
        nxt_s.refCnt  = st[14:0];
        nxt_s.refTick = st[15];
      end
      nxt_s.vcxoTick = 1'b0;
      if (vcxoRise)
      begin
        st             = divStep(s_ff.vcxoCnt, s_ff.vcxoFeedbackDivider);
        nxt_s.vcxoCnt  = st[14:0];
        nxt_s.vcxoTick = st[15];
      end

      // Second stage input: doubler, bypassed or divided pre-divider.
      nxt_s.synthTick = 1'b0;
      if (s_ff.synthDoublerSelect)
      begin
        nxt_s.synthTick = muxRise | muxFall;
      end
      else if (muxRise)
      begin
        if (s_ff.synthPreDivider == 6'h00)
        begin
          nxt_s.synthTick = 1'b1;
        end
        else
        begin
          st              = divStep({9'h000, s_ff.preCnt}, {9'h000, s_ff.synthPreDivider});
          nxt_s.preCnt    = st[5:0];
          nxt_s.synthTick = st[15];
        end
      end

      nxt_s.fbTick = 1'b0;
      if (vcoRise)
      begin
        st           = divStep({6'h00, s_ff.fbCnt}, {6'h00, s_ff.synthFeedbackDivider});
        nxt_s.fbCnt  = st[8:0];
        nxt_s.fbTick = st[15];
      end

      // Phase measurement between the two divided ticks.
      if (!s_ff.phRun)
      begin
        if (s_ff.refTick && s_ff.vcxoTick)
        begin
          pairDone = 1'b1;
          pairOk   = 1'b1;
        end
        else if (s_ff.refTick || s_ff.vcxoTick)
        begin
          nxt_s.phRun      = 1'b1;
          nxt_s.phRefFirst = s_ff.refTick;
          nxt_s.phCnt      = 16'h0001;
        end
      end
      else
      begin
        if (s_ff.phCnt != PH_MAX)
        begin
          nxt_s.phCnt = s_ff.phCnt + 16'h0001;
        end
        if ((s_ff.phRefFirst && s_ff.vcxoTick) || (!s_ff.phRefFirst && s_ff.refTick))
        begin
          pairDone    = 1'b1;
          pairOk      = s_ff.phCnt <= {1'b0, s_ff.lockPhaseWindow};
          nxt_s.phRun = 1'b0;
        end
        else if (s_ff.phCnt > {1'b0, s_ff.lockPhaseWindow})
        begin
          // Already outside the window; fail now rather than wait for the partner.
          pairDone    = 1'b1;
          nxt_s.phRun = 1'b0;
        end
      end

      if (pairDone)
      begin
        if (!pairOk)
        begin
          nxt_s.lockCnt = 10'h000;
        end
        else if (s_ff.lockCnt <= LOCK_CYCLES)
        begin
          nxt_s.lockCnt = s_ff.lockCnt + 10'h001;
        end
      end
      nxt_s.locked = (nxt_s.lockCnt > LOCK_CYCLES);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_ff                      <= '0;
      s_ff.pvLo                 <= PV_RST[7:0];
      s_ff.pvHi                 <= PV_RST[14:8];
      s_ff.refPreDivider        <= PV_RST;
      s_ff.mvLo                 <= MV_RST[7:0];
      s_ff.mvHi                 <= MV_RST[14:8];
      s_ff.vcxoFeedbackDivider  <= MV_RST;
      s_ff.lwLo                 <= LW_RST[7:0];
      s_ff.lwHi                 <= LW_RST[14:8];
      s_ff.lockPhaseWindow      <= LW_RST;
      s_ff.synthPreDivider      <= PF_RST;
      s_ff.mfLo                 <= MF_RST[7:0];
      s_ff.mfMsb                <= MF_RST[8];
      s_ff.synthFeedbackDivider <= MF_RST;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign regRdData        = s_ff.rdData;
  assign refDivTick       = s_ff.refTick;
  assign dividedVcxoClock = s_ff.vcxoTick;
  assign synthRefTick     = s_ff.synthTick;
  assign synthFbTick      = s_ff.fbTick;
  assign lockDetect       = s_ff.locked;

  ////////////////////////////////////////////////////////////////////////////////
  ref_div_reset_a: assert property (@(posedge clock) !rst_n |=> s_ff.refPreDivider == PV_RST)
    else $error("reference ratio not 1024 after reset");
  fb_div_reset_a: assert property (@(posedge clock) !rst_n |=> s_ff.vcxoFeedbackDivider == MV_RST)
    else $error("feedback ratio not 1024 after reset");
  lock_needs_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(lockDetect) |-> $past(s_ff.lockCnt) == LOCK_CYCLES)
    else $error("lock raised before 1001 good cycles");
  lock_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && pairDone && !pairOk |=> !lockDetect && s_ff.lockCnt == 10'h000)
    else $error("lock kept after a phase error");
  window_reset_a: assert property (@(posedge clock) !rst_n |=> s_ff.lockPhaseWindow == LW_RST)
    else $error("lock window not 128 after reset");
  prediv_bypass_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && muxRise && s_ff.synthPreDivider == 6'h00 && !s_ff.synthDoublerSelect
    |=> synthRefTick)
    else $error("zero pre-divider not bypassed");
  doubler_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && muxFall && s_ff.synthDoublerSelect |=> synthRefTick)
    else $error("doubler missed a falling edge");
  synth_fb_reset_a: assert property (@(posedge clock) !rst_n |=> s_ff.synthFeedbackDivider == MF_RST)
    else $error("second stage ratio not 24 after reset");
  reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && regRdEn && regAddr == ADDR_MF_MSB |=> regRdData[7:1] == 7'h00)
    else $error("reserved bits read nonzero");
  whole_ratio_a: assert property (@(posedge clock) disable iff (!rst_n)
    !$stable(s_ff.refPreDivider) |-> $past(regWrEn && ce && regAddr == ADDR_PV_HI))
    else $error("reference ratio changed without high byte write");
endmodule

/* verification/dpllc_bench.sv */
// Purpose: Self-checking bench for the dual PLL divider and lock block.
// Assumes: Slow clocks are driven at a quarter of the system clock rate.
// Notes:   Lock timing is checked with a margin of about 1000 system clocks, roughly 60 divided periods, either side.
`timescale 1ns/10ps
module dpllc_bench;
  import dpllc_pkg::*;
  logic       clock;
  logic       rst_n;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic       refClkIn;
  logic       vcxoClkIn;
  logic       vcoClkIn;
  logic       bypassSel;
  logic       refDivTick;
  logic       dividedVcxoClock;
  logic       synthRefTick;
  logic       synthFbTick;
  logic       lockDetect;
  logic       phase;
  logic       vcxoRun;
  logic       slowRun;
  logic [7:0] rdVal;
  int         errorCnt;
  int         checked;
  int         n;
  int         i;
  logic [7:0] rstAddr [12] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h19, 8'h1A,
                               8'h1B, 8'h14, 8'h17, 8'h18};
  logic [7:0] rstVal  [12] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h80, 8'h00, 8'h01, 8'h18,
                               8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] resAddr [5]  = '{8'h13, 8'h16, 8'h19, 8'h1B, 8'h11};
  logic [7:0] resVal  [5]  = '{8'h7F, 8'h7F, 8'hBF, 8'h01, 8'h7F};

  dpllc_core dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .refClkIn(refClkIn), .vcxoClkIn(vcxoClkIn), .vcoClkIn(vcoClkIn),
    .firstStageBypassSelect(bypassSel), .refDivTick(refDivTick),
    .dividedVcxoClock(dividedVcxoClock), .synthRefTick(synthRefTick),
    .synthFbTick(synthFbTick), .lockDetect(lockDetect));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // All three slow inputs toggle together while vcxoRun is set, so the divided edges line up and lock can build.
  // Stopping all of them at once lets a reset restart both dividers on the same edge.
  always @(negedge clock)
  begin
    phase <= ~phase;
    if (phase && slowRun)
    begin
      refClkIn  <= ~refClkIn;
      vcxoClkIn <= vcxoRun ? ~refClkIn : 1'b0;
      vcoClkIn  <= ~refClkIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic tick(input int sel);
    case (sel)
      0: return refDivTick;
      1: return dividedVcxoClock;
      2: return synthRefTick;
      default: return synthFbTick;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(negedge clock);
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRdEn = 1'b0;
    d = regRdData;
  endtask

  // The first two gaps are discarded because a ratio change may shorten one period.
  task automatic gap(input int sel, input int lim, output int cnt);
    int k;
    int c;
    c = 0;
    for (k = 0; k < 3; k++)
    begin
      c = 0;
      @(negedge clock);
      while (tick(sel) !== 1'b1 && c < lim)
      begin
        @(negedge clock);
        c++;
      end
      if (c >= lim) break;
    end
    cnt = (c >= lim) ? 0 : c + 1;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      errorCnt++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chkN(input string nm, input int e, input int g);
    checked++;
    if (g != e)
    begin
      errorCnt++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic summarize;
    $display("checked %0d errorCnt %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (80000) @(posedge clock);
    errorCnt++;
    summarize();
  end

  initial
  begin
    {rst_n, regWrEn, regRdEn, regAddr, regWrData} = '0;
    {refClkIn, vcxoClkIn, vcoClkIn, bypassSel, phase} = '0;
    {errorCnt, checked} = '0;
    vcxoRun = 1'b1;
    slowRun = 1'b1;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    for (i = 0; i < 12; i++)
    begin
      rd(rstAddr[i], rdVal);
      chk8("reset value", rstVal[i], rdVal);
    end
    gap(0, 5000, n);
    chkN("ref period", 4096, n);
    gap(1, 5000, n);
    chkN("vcxo period", 4096, n);
    gap(3, 200, n);
    chkN("fb period", 96, n);
    gap(2, 50, n);
    chkN("synth ref period", 4, n);
    for (i = 0; i < 5; i++)
    begin
      wr(resAddr[i], 8'hFF);
      rd(resAddr[i], rdVal);
      chk8("reserved bits", resVal[i], rdVal);
    end
    wr(8'h19, 8'h03);
    gap(2, 100, n);
    chkN("prediv 3", 12, n);
    wr(8'h19, 8'h00);
    gap(2, 100, n);
    chkN("prediv bypass", 4, n);
    wr(8'h19, 8'h85);
    gap(2, 100, n);
    chkN("doubler", 2, n);
    wr(8'h1A, 8'h09);
    wr(8'h1B, 8'h00);
    gap(3, 200, n);
    chkN("fb 9", 36, n);
    wr(8'h1A, 8'h08);
    rd(8'h1A, rdVal);
    chk8("staged low", 8'h08, rdVal);
    gap(3, 200, n);
    chkN("fb unchanged", 36, n);
    wr(8'h1B, 8'h01);
    gap(3, 2000, n);
    chkN("fb 264", 1056, n);
    wr(8'h19, 8'h01);
    vcxoRun = 1'b0;
    gap(2, 60, n);
    chkN("mux vcxo stopped", 0, n);
    bypassSel = 1'b1;
    gap(2, 60, n);
    chkN("mux bypass", 4, n);
    bypassSel = 1'b0;
    vcxoRun   = 1'b1;
    wr(8'h10, 8'h04);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h04);
    wr(8'h13, 8'h00);
    wr(8'h15, 8'h03);
    wr(8'h16, 8'h00);
    gap(0, 100, n);
    chkN("ref 4", 16, n);
    gap(1, 100, n);
    chkN("vcxo 4", 16, n);
    // A stalled divided VCXO exceeds the window and must clear any lock history.
    vcxoRun = 1'b0;
    repeat (300) @(negedge clock);
    chk8("lock lost", 8'h00, {7'h00, lockDetect});
    vcxoRun = 1'b1;
    // The stall leaves the two dividers out of step; a window below the feedback ratio
    // only passes aligned ticks, so both dividers restart together from a reset.
    repeat (4) @(negedge clock);
    slowRun = 1'b0;
    rst_n   = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    rd(8'h11, rdVal);
    chk8("reset again", 8'h04, rdVal);
    wr(8'h10, 8'h04);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h04);
    wr(8'h13, 8'h00);
    wr(8'h15, 8'h03);
    wr(8'h16, 8'h00);
    slowRun = 1'b1;
    repeat (15000) @(negedge clock);
    chk8("lock early", 8'h00, {7'h00, lockDetect});
    n = 0;
    while (lockDetect !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    chk8("lock reached", 8'h01, {7'h00, lockDetect});
    summarize();
  end
endmodule
